// ### rtl/astx_map.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  audio serial transmit master. Assumes byte addresses on a 12-bit APB bus.
*/
`ifndef ASTX_MAP_SVH
`define ASTX_MAP_SVH
// register byte offsets
`define ASTX_OFF_TX_CONTROL 12'h000
`define ASTX_OFF_CLOCK_CONTROL 12'h004
`define ASTX_OFF_STATUS 12'h008
`define ASTX_OFF_TX_DATA 12'h00c
// tx_control_reg fields
`define ASTX_CTL_ENABLE 0
`define ASTX_CTL_FMT_LSB 1
`define ASTX_CTL_SAMPLE_LSB 3
`define ASTX_CTL_SLOT_LSB 6
`define ASTX_CTL_PAD 9
`define ASTX_CTL_ACTIVE_LSB 10
`define ASTX_CTL_FSYNC 13
`define ASTX_CTL_W 14
`define ASTX_CTL_RST 14'h0000
// clock_control_reg fields
`define ASTX_CLK_DIV_LSB 0
`define ASTX_CLK_SRC 8
`define ASTX_CLK_W 9
`define ASTX_CLK_RST 9'h000
// status fields
`define ASTX_STS_RUN 0
`define ASTX_STS_LEVEL_LSB 1
`define ASTX_STS_SLOT_LSB 4
`define ASTX_STS_UNDER 7
// framing and divider counts
`define ASTX_SCK_HALF 2'd3
`define ASTX_TDM_SLOT_LEN 6'd32
`define ASTX_TDM_LAST_SLOT 3'd7
`define ASTX_STEREO_LAST_SLOT 3'd1
`define ASTX_WORD_BITS 6'd32
`define ASTX_BUF_DEPTH 3'd4
`endif

// ### rtl/astx_pkg.sv
/*
  Types of the audio serial transmit master: states, formats, serial
  carrier and the state records of both modules. Assumes astx_map.svh.
*/
package astx_pkg;
  // one-hot engine states
  typedef enum logic [1:0] {
    ASTX_ST_IDLE = 2'b01,
    ASTX_ST_RUN = 2'b10
  } astx_state_t;
  // serial formats
  typedef enum logic [1:0] {
    ASTX_FMT_STD = 2'h0,
    ASTX_FMT_LJ = 2'h1,
    ASTX_FMT_TDMA = 2'h2,
    ASTX_FMT_TDMB = 2'h3
  } astx_fmt_t;
  // pins toward the codec
  typedef struct packed {
    logic bit_clock;
    logic word_select;
    logic serial_out;
  } astx_serial_t;
  // transmit buffer state
  typedef struct packed {
    logic [3:0][31:0] words;
    logic [31:0] rdata;
  } astx_mem_t;
  // whole state of the transmitter
  typedef struct packed {
    astx_state_t st;
    logic [13:0] ctl;
    logic [8:0] clk;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic [5:0] div1;
    logic [1:0] half;
    logic sck;
    logic ws;
    logic sd;
    logic [5:0] bit_idx;
    logic [2:0] slot;
    logic [31:0] shreg;
    logic [1:0] wr_ptr;
    logic [1:0] rd_ptr;
    logic [2:0] level;
    logic under;
    logic [31:0] prdata;
  } astx_core_t;
endpackage

// ### rtl/astx_buf_mem.sv
/*
  Four-word transmit buffer storage with a registered read port.
  Assumes one clock; the owner keeps pointers and fill level.
*/
`timescale 1ns/1ps
`default_nettype none
module astx_buf_mem (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic wr_en_i,
  input wire logic [1:0] wr_addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic [1:0] rd_addr_i,
  output logic [31:0] rd_data_o
);
  astx_pkg::astx_mem_t r_reg; // stored words and read register
  astx_pkg::astx_mem_t r_next; // next value

  // write and read; a write to the word being read passes straight through
  // so a push into an empty buffer is visible one edge later
  always_comb begin
    r_next = r_reg;
    if (wr_en_i) begin
      r_next.words[wr_addr_i] = wr_data_i;
    end
    if (wr_en_i && wr_addr_i == rd_addr_i) begin
      r_next.rdata = wr_data_i;
    end else begin
      r_next.rdata = r_reg.words[rd_addr_i];
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rd_data_o = r_reg.rdata;
endmodule // astx_buf_mem
`default_nettype wire

// ### rtl/astx_tx_master.sv
/*
  Transmit-only audio serial master: APB registers, two-stage clock divider
  and serializer for the standard, left-justified and two TDM formats.
  Assumes one system clock; the external audio clock arrives as a plain
  input and is oversampled, so it must be well below half of clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "astx_map.svh"

module astx_tx_master (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic external_bus_clock_i,
  output astx_pkg::astx_serial_t serial_o
);
  astx_pkg::astx_core_t r_reg; // all state
  astx_pkg::astx_core_t r_next; // next state
  logic access; // apb access phase
  logic setup; // apb setup phase
  logic mapped; // address hits a register
  logic full; // buffer holds four words
  logic push; // accepted data write
  logic pop; // word taken by the serializer
  logic src_tick; // one tick of the selected source
  logic mclk_tick; // internal master clock enable
  logic fall; // bit clock falling edge event
  logic tdm; // a tdm variant is selected
  astx_pkg::astx_fmt_t fmt; // selected format
  logic [5:0] swid; // sample width in bits
  logic [5:0] slen; // slot length in bits
  logic [2:0] last_slot; // highest slot number
  logic [8:0] npos; // next position {slot,bit}
  logic [8:0] lpos; // position after that
  logic active; // next slot carries data
  logic [31:0] word; // word entering the slot
  logic [31:0] sh; // shift register next value
  logic [31:0] rd_word; // buffer head
  logic [31:0] rd_value; // register read mux

  // width code to bits; unknown codes act as 32
  function automatic logic [5:0] width_of(input logic [2:0] code);
    case (code)
      3'h0: width_of = 6'd8;
      3'h1: width_of = 6'd16;
      3'h2: width_of = 6'd18;
      3'h3: width_of = 6'd20;
      3'h4: width_of = 6'd24;
      default: width_of = 6'd32;
    endcase
  endfunction

  // step one bit through the frame, wrapping slot and frame
  function automatic logic [8:0] next_pos(input logic [8:0] pos,
                                          input logic [5:0] len,
                                          input logic [2:0] last);
    logic [2:0] s;
    logic [5:0] b;
    s = pos[8:6];
    b = pos[5:0];
    if (b == len - 6'd1) begin
      b = 6'd0;
      s = (s == last) ? 3'd0 : s + 3'd1;
    end else begin
      b = b + 6'd1;
    end
    next_pos = {s, b};
  endfunction

  // word select level for the bit at pos, lead is the bit after it
  function automatic logic ws_calc(input astx_pkg::astx_fmt_t f,
                                   input logic wide,
                                   input logic [8:0] pos,
                                   input logic [8:0] lead);
    case (f)
      astx_pkg::ASTX_FMT_STD: ws_calc = lead[6];
      astx_pkg::ASTX_FMT_LJ: ws_calc = (pos[8:6] == 3'd0);
      astx_pkg::ASTX_FMT_TDMA: ws_calc = (pos[8:6] == 3'd0) &&
                                         (wide || pos[5:0] == 6'd0);
      default: ws_calc = (lead[8:6] == 3'd0) &&
                         (wide || lead[5:0] == 6'd0);
    endcase
  endfunction

  // format decode; one format at a time from one field
  assign fmt = astx_pkg::astx_fmt_t'(r_reg.ctl[`ASTX_CTL_FMT_LSB +: 2]);
  assign tdm = fmt[1];
  assign swid = width_of(r_reg.ctl[`ASTX_CTL_SAMPLE_LSB +: 3]);
  // tdm fixes the slot at 32 bits and eight slots per frame
  assign slen = tdm ? `ASTX_TDM_SLOT_LEN :
                width_of(r_reg.ctl[`ASTX_CTL_SLOT_LSB +: 3]);
  assign last_slot = tdm ? `ASTX_TDM_LAST_SLOT : `ASTX_STEREO_LAST_SLOT;

  // apb decode
  assign access = psel_i & penable_i;
  assign setup = psel_i & ~penable_i;
  assign full = (r_reg.level == `ASTX_BUF_DEPTH);
  always_comb begin
    case (paddr_i)
      `ASTX_OFF_TX_CONTROL: mapped = 1'b1;
      `ASTX_OFF_CLOCK_CONTROL: mapped = 1'b1;
      `ASTX_OFF_STATUS: mapped = 1'b1;
      `ASTX_OFF_TX_DATA: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // register read values; data register reads as zero
  always_comb begin
    rd_value = 32'h0000_0000;
    case (paddr_i)
      `ASTX_OFF_TX_CONTROL: rd_value[`ASTX_CTL_W-1:0] = r_reg.ctl;
      `ASTX_OFF_CLOCK_CONTROL: rd_value[`ASTX_CLK_W-1:0] = r_reg.clk;
      `ASTX_OFF_STATUS: begin
        rd_value[`ASTX_STS_RUN] = (r_reg.st == astx_pkg::ASTX_ST_RUN);
        rd_value[`ASTX_STS_LEVEL_LSB +: 3] = r_reg.level;
        rd_value[`ASTX_STS_SLOT_LSB +: 3] = r_reg.slot;
        rd_value[`ASTX_STS_UNDER] = r_reg.under;
      end
      default: rd_value = 32'h0000_0000;
    endcase
  end

  // zero wait states; error on unmapped or on a write into a full buffer
  assign pready_o = 1'b1;
  assign pslverr_o = access & (~mapped |
                     (pwrite_i & (paddr_i == `ASTX_OFF_TX_DATA) & full));
  assign push = access & pwrite_i & (paddr_i == `ASTX_OFF_TX_DATA) & ~full;

  // clock source tick; external clock is oversampled, only the second
  // and third stages feed the edge detector
  assign src_tick = r_reg.clk[`ASTX_CLK_SRC] ? (r_reg.ext_s2 & ~r_reg.ext_s3)
                    : 1'b1;
  // first divider: ratio is field value plus one, 1 to 64
  assign mclk_tick = src_tick &&
                     (r_reg.div1 == r_reg.clk[`ASTX_CLK_DIV_LSB +: 6]);
  // second divider: four master ticks per half period gives eight
  assign fall = (r_reg.st == astx_pkg::ASTX_ST_RUN) && mclk_tick &&
                (r_reg.half == `ASTX_SCK_HALF) && r_reg.sck;

  // position of the bit driven at this fall and the one after it
  assign npos = next_pos({r_reg.slot, r_reg.bit_idx}, slen, last_slot);
  assign lpos = next_pos(npos, slen, last_slot);
  // active slots come first; outside tdm both channels carry data
  assign active = tdm ? (npos[8:6] <= r_reg.ctl[`ASTX_CTL_ACTIVE_LSB +: 3])
                  : 1'b1;
  assign pop = fall && (npos[5:0] == 6'd0) && active && (r_reg.level != 3'd0);
  // an empty buffer sends a silent word and flags underrun
  assign word = (r_reg.level != 3'd0) ? rd_word : 32'h0000_0000;
  // load left-aligned so the top bit is the sample msb, then shift left
  assign sh = (npos[5:0] == 6'd0) ? (word << (`ASTX_WORD_BITS - swid))
              : (r_reg.shreg << 1);

  // next-state logic of registers, divider and serializer
  always_comb begin
    r_next = r_reg;
    // apb writes take effect at the access edge
    if (access && pwrite_i && !pslverr_o) begin
      case (paddr_i)
        `ASTX_OFF_TX_CONTROL: r_next.ctl = pwdata_i[`ASTX_CTL_W-1:0];
        `ASTX_OFF_CLOCK_CONTROL: r_next.clk = pwdata_i[`ASTX_CLK_W-1:0];
        `ASTX_OFF_STATUS: begin
          if (pwdata_i[`ASTX_STS_UNDER]) begin
            r_next.under = 1'b0; // write one to clear
          end
        end
        default: r_next.under = r_reg.under; // data write handled by push
      endcase
    end
    // read data captured in the setup phase, stable through access
    if (setup && !pwrite_i) begin
      r_next.prdata = rd_value;
    end
    // external clock synchroniser and edge stage
    r_next.ext_s1 = external_bus_clock_i;
    r_next.ext_s2 = r_reg.ext_s1;
    r_next.ext_s3 = r_reg.ext_s2;
    // buffer pointers and fill level
    if (push) begin
      r_next.wr_ptr = r_reg.wr_ptr + 2'd1;
    end
    if (pop) begin
      r_next.rd_ptr = r_reg.rd_ptr + 2'd1;
    end
    r_next.level = r_reg.level + {2'b00, push} - {2'b00, pop};
    case (r_reg.st)
      astx_pkg::ASTX_ST_IDLE: begin
        // park on the last bit of the frame so the first fall lands on
        // slot 0 bit 0; bit clock idles high so that edge is a fall
        r_next.div1 = 6'd0;
        r_next.half = 2'd0;
        r_next.sck = 1'b1;
        r_next.sd = 1'b0;
        r_next.slot = last_slot;
        r_next.bit_idx = slen - 6'd1;
        r_next.ws = 1'b0;
        if (r_reg.ctl[`ASTX_CTL_ENABLE]) begin
          r_next.st = astx_pkg::ASTX_ST_RUN;
        end
      end
      astx_pkg::ASTX_ST_RUN: begin
        if (!r_reg.ctl[`ASTX_CTL_ENABLE]) begin
          // stop at once; a word half sent is cut short
          r_next.st = astx_pkg::ASTX_ST_IDLE;
        end else begin
          if (src_tick) begin
            r_next.div1 = mclk_tick ? 6'd0 : r_reg.div1 + 6'd1;
          end
          if (mclk_tick) begin
            r_next.half = r_reg.half + 2'd1;
            if (r_reg.half == `ASTX_SCK_HALF) begin
              r_next.sck = ~r_reg.sck;
            end
          end
          // data and word select only move on the falling edge
          if (fall) begin
            r_next.slot = npos[8:6];
            r_next.bit_idx = npos[5:0];
            r_next.shreg = sh;
            if (npos[5:0] == 6'd0 && active && r_reg.level == 3'd0) begin
              r_next.under = 1'b1; // set wins over a same-cycle clear
            end
            // past the sample, or in an idle slot, send the pad level
            if (active && npos[5:0] < swid) begin
              r_next.sd = sh[31];
            end else begin
              r_next.sd = r_reg.ctl[`ASTX_CTL_PAD];
            end
            r_next.ws = ws_calc(fmt, r_reg.ctl[`ASTX_CTL_FSYNC], npos,
                                lpos);
          end
        end
      end
      default: r_next.st = astx_pkg::ASTX_ST_IDLE;
    endcase
  end

  // state register; every field takes a constant at reset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r_reg <= '0;
      r_reg.st <= astx_pkg::ASTX_ST_IDLE;
      r_reg.ctl <= `ASTX_CTL_RST;
      r_reg.clk <= `ASTX_CLK_RST;
      r_reg.sck <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // four-word transmit buffer between the bus and the serializer
  astx_buf_mem u_buf (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .wr_en_i(push),
    .wr_addr_i(r_reg.wr_ptr),
    .wr_data_i(pwdata_i),
    .rd_addr_i(r_reg.rd_ptr),
    .rd_data_o(rd_word)
  );

  // outputs straight from flip-flops
  assign prdata_o = r_reg.prdata;
  assign serial_o.bit_clock = r_reg.sck;
  assign serial_o.word_select = r_reg.ws;
  assign serial_o.serial_out = r_reg.sd;
endmodule // astx_tx_master
`default_nettype wire

// ### dv/astx_tx_master_chk.sv
/* port checker of the audio serial transmit master.
   Assumes the internal source ticks on every clk_i and no disable mid-frame. */
`timescale 1ns/1ps
`default_nettype none
module astx_tx_master_chk (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic external_bus_clock_i,
  input wire astx_pkg::astx_serial_t serial_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [13:0] ctl_reg; // shadow of control writes
  logic [8:0] clk_reg; // shadow of clock writes
  logic sck_reg, ws_reg, tgl_reg; // previous levels, toggle seen
  logic [1:0] rise_reg; // ws rises seen, saturating
  logic [19:0] sck_cnt, hi_cnt, fr_cnt, bitc, slot_b;
  wire logic acc = psel_i && penable_i;
  wire logic bad = paddr_i > 12'h00c;
  wire logic wsr = serial_o.word_select && !ws_reg;
  wire logic wsf = !serial_o.word_select && ws_reg;
  wire logic tdm = ctl_reg[2];
  // only tdm b with a slot-wide pulse starts short, so it alone waits
  wire logic regular = ctl_reg[2:1] != 2'h3 || !ctl_reg[13] || rise_reg == 2'h2;
  // bit period in clk_i cycles and slot length in bits
  always_comb begin
    bitc = (20'(clk_reg[5:0]) + 20'h1) << 3;
    case (ctl_reg[8:6])
      3'h0: slot_b = 20'd8;
      3'h1: slot_b = 20'd16;
      3'h2: slot_b = 20'd18;
      3'h3: slot_b = 20'd20;
      3'h4: slot_b = 20'd24;
      default: slot_b = 20'd32;
    endcase
  end
  // shadows and interval counters
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctl_reg <= 14'h0000;
      clk_reg <= 9'h000;
      sck_reg <= 1'b1;
      ws_reg <= 1'b0;
      tgl_reg <= 1'b0;
      rise_reg <= 2'h0;
      sck_cnt <= 20'h0;
      hi_cnt <= 20'h0;
      fr_cnt <= 20'h0;
    end else begin
      if (acc && pwrite_i && paddr_i == 12'h000) ctl_reg <= pwdata_i[13:0];
      if (acc && pwrite_i && paddr_i == 12'h004) clk_reg <= pwdata_i[8:0];
      sck_reg <= serial_o.bit_clock;
      ws_reg <= serial_o.word_select;
      tgl_reg <= tgl_reg || serial_o.bit_clock != sck_reg;
      sck_cnt <= serial_o.bit_clock != sck_reg ? 20'h1 : sck_cnt + 20'h1;
      hi_cnt <= wsr ? 20'h1 : hi_cnt + 20'h1;
      fr_cnt <= wsr ? 20'h1 : fr_cnt + 20'h1;
      if (wsr && rise_reg != 2'h2) rise_reg <= rise_reg + 2'h1;
    end
  end
  data_low_a: assert property ($changed(serial_o.serial_out) |-> !serial_o.bit_clock)
    else $error("serial data moved while bit clock high");
  ws_low_a: assert property ($changed(serial_o.word_select) |-> !serial_o.bit_clock)
    else $error("word select moved while bit clock high");
  sck_half_a: assert property (serial_o.bit_clock != sck_reg && tgl_reg && !clk_reg[8]
    |-> sck_cnt == bitc >> 1) else $error("bit clock half period wrong");
  sck_low_a: assert property ($fell(serial_o.bit_clock) |-> !serial_o.bit_clock [*4])
    else $error("bit clock low phase too short");
  frame_len_a: assert property (wsr && rise_reg != 2'h0 && regular && !clk_reg[8]
    |-> fr_cnt == (tdm ? 20'd256 : slot_b << 1) * bitc) else $error("frame length wrong");
  sync_width_a: assert property (wsf && regular && !clk_reg[8]
    |-> hi_cnt == (tdm ? (ctl_reg[13] ? 20'd32 : 20'd1) : slot_b) * bitc)
    else $error("word select pulse width wrong");
  bad_err_a: assert property (acc && bad |-> pslverr_o)
    else $error("unmapped access not refused");
  bad_zero_a: assert property (acc && bad && !pwrite_i |-> prdata_o == 32'h0)
    else $error("unmapped read not zero");
  ready_a: assert property (acc |-> pready_o)
    else $error("access phase not ready");
endmodule // astx_tx_master_chk
bind astx_tx_master astx_tx_master_chk chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .external_bus_clock_i(external_bus_clock_i), .serial_o(serial_o));
`default_nettype wire

// ### dv/astx_codec_model.sv
/* behavioural receiving codec: samples word select and data on bit clock rise.
   Assumes the bench reads its queues; it drives nothing back. */
`timescale 1ns/1ps
`default_nettype none
module astx_codec_model (
  input wire logic reset_n_i,
  input wire astx_pkg::astx_serial_t serial_i
);
  logic sd_q[$]; // data bits in arrival order
  logic ws_q[$]; // word select beside each bit
  // receiver samples on the rise; supplies no clock of its own
  always @(posedge serial_i.bit_clock or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sd_q.delete();
      ws_q.delete();
    end else begin
      sd_q.push_back(serial_i.serial_out);
      ws_q.push_back(serial_i.word_select);
    end
  end
endmodule // astx_codec_model
`default_nettype wire

// ### dv/test_audio_serial_tx_master.sv
/* self-checking bench of the audio serial transmit master over APB.
   Assumes the codec model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module test_audio_serial_tx_master;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  logic [2:0] ext_cnt = 3'h0; // external audio clock, an eighth of clk_i
  astx_pkg::astx_serial_t ser;
  int fail_count = 0, comparisons = 0, seed = 73404, cycles = 0;
  int fmt, fs, pad, act, slot_len, samp_len, frame_len;
  logic [31:0] wq[$]; // accepted words in push order
  astx_tx_master dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .external_bus_clock_i(ext_cnt[2]), .serial_o(ser));
  astx_codec_model rx_u (.reset_n_i(reset_n_i), .serial_i(ser));
  initial forever #2.5 clk_i = ~clk_i;
  // external clock and hang guard
  always @(posedge clk_i) begin
    ext_cnt <= ext_cnt + 3'h1;
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      fail_count = fail_count + 1;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp_v, input logic [31:0] got);
    comparisons++;
    if (got !== exp_v) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp_v, got);
    end
  endtask
  // one transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    // no wait limit here; the bench timeout ends a hung transfer
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // right-aligned random sample; kept only if accepted
  task automatic push(output logic e);
    logic [31:0] d, q;
    d = $random(seed) & 32'((64'h1 << samp_len) - 1);
    apb(1'b1, 12'h00c, d, q, e);
    if (e === 1'b0) wq.push_back(d);
  endtask
  function automatic int wid(input int c);
    return c == 0 ? 8 : c == 1 ? 16 : c == 2 ? 18 : c == 3 ? 20 : c == 4 ? 24 : 32;
  endfunction
  // expected {word select, data} at received bit k
  function automatic logic [1:0] exp_bit(input int k);
    int p, s, j, n;
    logic w, d;
    p = k % frame_len;
    s = p / slot_len;
    j = p % slot_len;
    n = (k + 1) % frame_len;
    d = (s < act && j < samp_len) ? wq[(k / frame_len) * act + s][samp_len - 1 - j] : pad[0];
    case (fmt)
      0: w = n >= slot_len;
      1: w = s == 0;
      2: w = fs ? s == 0 : p == 0;
      default: w = fs ? n < 32 : n == 0;
    endcase
    return {w, d};
  endfunction
  task automatic run(input int f, input int fsv, input int pv, input int av, input logic src);
    logic [31:0] q, ctl;
    logic e;
    int sc, wc, div, k, need, fc, t0;
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    fmt = f;
    fs = fsv;
    pad = pv;
    div = {$random(seed)} % 2;
    sc = f > 1 ? 5 : {$random(seed)} % 6;
    wc = {$random(seed)} % (sc + 1);
    slot_len = wid(sc);
    samp_len = wid(wc);
    act = f > 1 ? av : 2;
    frame_len = f > 1 ? 256 : 2 * slot_len;
    ctl = 32'(f << 1 | wc << 3 | sc << 6 | pv << 9 | (act - 1) << 10 | fsv << 13);
    wq.delete();
    apb(1'b1, 12'h004, 32'(div) | 32'(src) << 8, q, e);
    apb(1'b1, 12'h000, ctl, q, e);
    repeat (4) push(e);
    check("prefill error", 32'h0, 32'(e));
    push(e);
    check("full buffer error", 32'h1, 32'(e));
    apb(1'b0, 12'h008, 32'h0, q, e);
    check("buffer level", 32'h4, 32'(q[3:1]));
    apb(1'b0, 12'h010, 32'h0, q, e);
    check("unmapped read", 32'h0, q);
    check("unmapped error", 32'h1, 32'(e));
    apb(1'b1, 12'h000, ctl | 32'h1, q, e);
    // one whole bit period in clk_i cycles; external ticks every eighth clk_i
    @(posedge ser.bit_clock);
    t0 = cycles;
    @(posedge ser.bit_clock);
    check("bit period", 32'(8 * (div + 1) * (src ? 8 : 1)), 32'(cycles - t0));
    apb(1'b0, 12'h008, 32'h0, q, e);
    check("running flag", 32'h1, 32'(q[0]));
    // tdm b needs two frames before the checker sees a whole one
    need = (f == 3 ? 2 : 1) * frame_len + 2 * slot_len;
    // keep the buffer topped up while the codec collects bits
    while (rx_u.sd_q.size() < need) push(e);
    fc = fail_count;
    for (k = 0; k < need && fail_count == fc; k++) begin
      check("serial bit", 32'(exp_bit(k)), 32'({rx_u.ws_q[k], rx_u.sd_q[k]}));
    end
  endtask
  initial begin
    // run() holds reset two more edges, 16 in all at the start
    repeat (14) @(posedge clk_i);
    run(0, 0, 0, 2, 1'b0);
    run(1, 0, 1, 2, 1'b0);
    run(2, 0, 1, 4, 1'b0);
    run(3, 1, 0, 8, 1'b0);
    run(2, 1, 0, 1, 1'b0);
    run(3, 0, 1, 6, 1'b0);
    run(0, 0, 1, 2, 1'b1);
    complete_run();
  end
endmodule // test_audio_serial_tx_master
`default_nettype wire
